// ==== rtl/driver_status_failsafe_monitor.v ====
`timescale 1ns/1ps
`include "drv_status_regs.vh"
module driver_status_failsafe_monitor #(
    parameter CHANNELS = 6
) (
    input  wire                mclk,
    input  wire                rstn,
    input  wire                hsel,
    input  wire [11:0]         haddr,
    input  wire [1:0]          htrans,
    input  wire                hwrite,
    input  wire [2:0]          hsize,
    input  wire [31:0]         hwdata,
    input  wire                hready,
    output wire                hreadyout,
    output wire                hresp,
    output reg  [31:0]         hrdata,
    input  wire [CHANNELS-1:0] nodeComparator,
    input  wire                failsafeRequest,
    input  wire                commError,
    output wire [CHANNELS-1:0] gateHigh,
    output wire [CHANNELS-1:0] gateLow,
    output wire                failsafe,
    output wire                irq
);
    // ----------------------------------------
    // Bus address phase capture
    // ----------------------------------------
    reg        aValid;
    reg        aWrite;
    reg [11:0] aAddr;

    always @(posedge mclk) begin
        if (!rstn) begin
            aValid <= 1'b0;
            aWrite <= 1'b0;
            aAddr  <= 12'h000;
        end else if (hready) begin
            aValid <= hsel & htrans[1];
            aWrite <= hwrite;
            aAddr  <= haddr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire wrStrobe = aValid & aWrite;
    wire rdStrobe = aValid & ~aWrite;

    // ----------------------------------------
    // Mode and control state
    // ----------------------------------------
    reg                      failsafeMode;
    reg                      resetFlag;
    reg                      wdBit;
    reg [CHANNELS-1:0]       hbEnable;
    reg [CHANNELS-1:0]       hbHighOn;
    reg [CHANNELS-1:0]       pwmMode;
    reg [`IRQ_WIDTH-1:0]     irqStatus;
    reg [`IRQ_WIDTH-1:0]     irqMask;

    wire ctlWrite   = wrStrobe && aAddr == `OFS_CONTROL;
    wire wdToggled  = ctlWrite && (hwdata[`CTL_WD_BIT] != wdBit);
    // The exit needs request low; a held request keeps failsafe
    wire exitReq    = failsafeMode && wdToggled && !failsafeRequest;
    wire enterReq   = !failsafeMode && (failsafeRequest || commError);
    wire rejected   = ctlWrite && failsafeMode;
    wire resetRead  = rdStrobe && aAddr == `OFS_MODE_STATUS;

    always @(posedge mclk) begin
        if (!rstn) begin
            failsafeMode <= 1'b0;
            resetFlag    <= 1'b1;
            wdBit        <= 1'b0;
            hbEnable     <= {CHANNELS{1'b0}};
            hbHighOn     <= {CHANNELS{1'b0}};
            pwmMode      <= {CHANNELS{1'b0}};
        end else begin
            if (enterReq) begin
                // Status and control left untouched for diagnosis
                failsafeMode <= 1'b1;
            end else if (exitReq) begin
                failsafeMode <= 1'b0;
                resetFlag    <= 1'b1;
                wdBit        <= hwdata[`CTL_WD_BIT];
                hbEnable     <= {CHANNELS{1'b0}};
                hbHighOn     <= {CHANNELS{1'b0}};
                pwmMode      <= {CHANNELS{1'b0}};
            end else if (ctlWrite && !failsafeMode) begin
                wdBit    <= hwdata[`CTL_WD_BIT];
                hbEnable <= hwdata[`CTL_HB_EN_LSB +: CHANNELS];
                hbHighOn <= hwdata[`CTL_HB_ON_LSB +: CHANNELS];
                pwmMode  <= hwdata[`CTL_PWM_LSB +: CHANNELS];
            end
            // Reading the mode word de-latches the reset flag
            if (resetRead && !exitReq) begin
                resetFlag <= 1'b0;
            end
        end
    end

    assign failsafe = failsafeMode;

    // ----------------------------------------
    // Gate command and switch state
    // ----------------------------------------
    wire [2*CHANNELS-1:0] switchState;

    gate_state_encoder #(
        .CHANNELS (CHANNELS)
    ) u_enc (
        .hbEnable    (hbEnable),
        .hbHighOn    (hbHighOn),
        .pwmMode     (pwmMode),
        .failsafe    (failsafeMode),
        .gateHigh    (gateHigh),
        .gateLow     (gateLow),
        .switchState (switchState)
    );

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    wire [`IRQ_WIDTH-1:0] irqEvent;
    wire [`IRQ_WIDTH-1:0] irqClear;

    assign irqEvent = {rejected, exitReq, enterReq};
    assign irqClear = (wrStrobe && aAddr == `OFS_IRQ_STATUS) ? hwdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

    always @(posedge mclk) begin
        if (!rstn) begin
            irqStatus <= {`IRQ_WIDTH{1'b0}};
            irqMask   <= `RST_IRQ_MASK;
        end else begin
            // Set wins over a clear in the same cycle
            irqStatus <= (irqStatus & ~irqClear) | irqEvent;
            if (wrStrobe && aAddr == `OFS_IRQ_MASK) begin
                irqMask <= hwdata[`IRQ_WIDTH-1:0];
            end
        end
    end

    assign irq = |(irqStatus & irqMask);

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Combinational read mux, sampled at the address phase edge below
    reg [31:0] next_hrdata;

    always @* begin
        next_hrdata = 32'h0000_0000;
        case (haddr)
            `OFS_CONTROL: begin
                next_hrdata[`CTL_WD_BIT]               = wdBit;
                next_hrdata[`CTL_HB_EN_LSB +: CHANNELS] = hbEnable;
                next_hrdata[`CTL_HB_ON_LSB +: CHANNELS] = hbHighOn;
                next_hrdata[`CTL_PWM_LSB +: CHANNELS]   = pwmMode;
            end
            `OFS_DRIVER_STATUS: begin
                next_hrdata[2*CHANNELS-1:0] = switchState;
            end
            `OFS_NODE_STATUS: begin
                // Live comparator, no history kept
                next_hrdata[CHANNELS-1:0] = nodeComparator;
            end
            `OFS_MODE_STATUS: begin
                next_hrdata[`MST_FAILSAFE_BIT] = failsafeMode;
                next_hrdata[`MST_RESET_BIT]    = resetFlag;
                next_hrdata[`MST_REQ_BIT]      = failsafeRequest;
            end
            `OFS_IRQ_STATUS: begin
                next_hrdata[`IRQ_WIDTH-1:0] = irqStatus;
            end
            `OFS_IRQ_MASK: begin
                next_hrdata[`IRQ_WIDTH-1:0] = irqMask;
            end
            default: begin
                next_hrdata = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end
endmodule

// ==== rtl/drv_status_regs.vh ====
// Behaviour
// - Each channel shows a high-side and low-side switch-state flag in the driver status word.
// - Each switch-state flag equals its gate driver's current commanded logic state.
// - An enabled channel in PWM mode reports both its switch-state flags as one, except in failsafe mode.
// - In normal mode the host may read switch and node states over the bus.
// - Each half-bridge has a node-level flag from its half-supply comparator.
// - Node-level flags are not latched; each read returns the present comparator state.
// - Asserting the failsafe request input puts the device into failsafe mode.
// - Toggling watchdog bit with request low returns to normal, clears registers, sets reset flag.
// - Entering failsafe keeps the status registers intact for diagnosis.
// - In failsafe mode, commands that control the outputs are rejected.
// - A communication error puts the device into failsafe mode at once.
`ifndef DRV_STATUS_REGS_VH
`define DRV_STATUS_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CONTROL       12'h000
`define OFS_DRIVER_STATUS 12'h004
`define OFS_NODE_STATUS   12'h008
`define OFS_MODE_STATUS   12'h00c
`define OFS_IRQ_STATUS    12'h010
`define OFS_IRQ_MASK      12'h014

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_WD_BIT        0
`define CTL_HB_EN_LSB     8
`define CTL_HB_ON_LSB     16
`define CTL_PWM_LSB       24

// ----------------------------------------
// Mode status fields
// ----------------------------------------
`define MST_FAILSAFE_BIT  0
`define MST_RESET_BIT     1
`define MST_REQ_BIT       2

// ----------------------------------------
// Interrupt status fields
// ----------------------------------------
`define IRQ_FS_ENTER_BIT  0
`define IRQ_FS_EXIT_BIT   1
`define IRQ_REJECT_BIT    2
`define IRQ_WIDTH         3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CONTROL       32'h0000_0000
`define RST_IRQ_MASK      3'h0

`endif

// ==== rtl/gate_state_encoder.v ====
`timescale 1ns/1ps
module gate_state_encoder #(
    parameter CHANNELS = 6
) (
    input  wire [CHANNELS-1:0]   hbEnable,
    input  wire [CHANNELS-1:0]   hbHighOn,
    input  wire [CHANNELS-1:0]   pwmMode,
    input  wire                  failsafe,
    output wire [CHANNELS-1:0]   gateHigh,
    output wire [CHANNELS-1:0]   gateLow,
    output wire [2*CHANNELS-1:0] switchState
);
    // ----------------------------------------
    // Gate commands
    // ----------------------------------------
    // PWM drive on an enabled channel toggles both switches, so both flags read one outside failsafe
    assign gateHigh = failsafe ? {CHANNELS{1'b0}} : (hbEnable & (hbHighOn | pwmMode));
    assign gateLow  = failsafe ? {CHANNELS{1'b0}} : (hbEnable & (~hbHighOn | pwmMode));

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
            assign switchState[2*i]   = gateLow[i];
            assign switchState[2*i+1] = gateHigh[i];
        end
    endgenerate
endmodule

// ==== sim/dsfm_chk.sv ====
`timescale 1ns/1ps
module dsfm_chk #(
    parameter CHANNELS = 6
) (
    input wire                mclk,
    input wire                rstn,
    input wire                hreadyout,
    input wire                hresp,
    input wire                failsafeRequest,
    input wire                commError,
    input wire [CHANNELS-1:0] gateHigh,
    input wire [CHANNELS-1:0] gateLow,
    input wire                failsafe
);
    // ----------
    // Bus and mode checks
    // ----------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_req; failsafeRequest && !failsafe; endsequence
    sequence s_err; commError && !failsafe; endsequence
    property p_bus; hreadyout && !hresp; endproperty
    property p_req; s_req |=> failsafe; endproperty
    property p_err; s_err |=> failsafe; endproperty
    property p_hold; failsafeRequest && failsafe |=> failsafe; endproperty
    property p_stay; s_req ##1 failsafeRequest [*3] |-> failsafe; endproperty
    property p_off; failsafe |-> !gateHigh && !gateLow; endproperty
    property p_exit; $fell(failsafe) |-> !$past(failsafeRequest); endproperty
    property p_cause; $rose(failsafe) |-> $past(failsafeRequest) || $past(commError); endproperty
    a_bus: assert property (p_bus) else $error("bus not ready");
    a_req: assert property (p_req) else $error("no entry on request");
    a_err: assert property (p_err) else $error("no entry on error");
    a_hold: assert property (p_hold) else $error("left while requested");
    a_stay: assert property (p_stay) else $error("not held");
    a_off: assert property (p_off) else $error("gate on in failsafe");
    a_exit: assert property (p_exit) else $error("bad exit");
    a_cause: assert property (p_cause) else $error("entry without cause");
endmodule

bind driver_status_failsafe_monitor dsfm_chk #(.CHANNELS(CHANNELS)) dsfm_chk_i (
    .mclk(mclk), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp), .failsafeRequest(failsafeRequest),
    .commError(commError), .gateHigh(gateHigh), .gateLow(gateLow), .failsafe(failsafe));

// ==== sim/watchdog_model.sv ====
`timescale 1ns/1ps
module watchdog_model (
    input  wire  mclk,
    input  wire  trip,
    output logic failsafeRequest
);
    // --------------
    // Host supervisor
    // --------------
    initial failsafeRequest = 1'b0;
    always @(posedge mclk) failsafeRequest <= trip;
endmodule

// ==== sim/driver_status_failsafe_monitor_tb_top.sv ====
`timescale 1ns/1ps
module driver_status_failsafe_monitor_tb_top;
    // -----------
    // Host side
    // -----------
    logic        mclk = '0, rstn = '0, hsel = '0, hwrite = '0, commError = '0, trip = '0, dph = '0;
    logic [1:0]  htrans = '0;
    logic [5:0]  nodeComparator = '0;
    logic [11:0] haddr = '0;
    logic [31:0] hwdata = '0, c, n, q[$];
    wire         hreadyout, hresp, failsafe, irq, failsafeRequest;
    wire  [5:0]  gateHigh, gateLow;
    wire  [31:0] hrdata;
    integer      fails = 0, checked = 0, seed = 10135, i;
    always #2.5 mclk = ~mclk;
    watchdog_model watchdog_model_i (.mclk(mclk), .trip(trip), .failsafeRequest(failsafeRequest));
    driver_status_failsafe_monitor driver_status_failsafe_monitor_i (
        .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .nodeComparator(nodeComparator), .failsafeRequest(failsafeRequest), .commError(commError),
        .gateHigh(gateHigh), .gateLow(gateLow), .failsafe(failsafe), .irq(irq));
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    // A read passes its expected word in d; it is queued, and also driven on hwdata
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        dph <= !w;
        if (!w) q.push_back(d);
        do @(posedge mclk); while (hreadyout !== 1'b1);
        dph <= 1'b0;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    function automatic logic [31:0] dexp(input logic [31:0] v);
        dexp = '0;
        for (int k = 0; k < 6; k++) begin
            dexp[2*k] = v[8+k] & (v[24+k] | ~v[16+k]);
            dexp[2*k+1] = v[8+k] & (v[24+k] | v[16+k]);
        end
    endfunction
    always @(posedge mclk) if (dph && hreadyout) cmp("hrdata", q.pop_front(), hrdata);
    task stop_test;
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        fails++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        bus(0, 'hc, 'h2);
        for (i = 0; i < 5; i++) begin
            c = i ? $random(seed) & 'h3f3f3f00 : 'h3f003f00;
            n = $random(seed) & 'h3f;
            nodeComparator <= n[5:0];
            bus(1, 'h0, c);
            bus(0, 'h4, dexp(c));
            bus(0, 'h8, n);
        end
        bus(1, 'h14, 'h1);
        trip <= 1'b1;
        cyc(3);
        cmp("failsafe", 1, failsafe);
        cmp("gates", 0, {gateHigh, gateLow});
        cmp("irq", 1, irq);
        bus(0, 'hc, 'h5);
        bus(1, 'h0, 'h1);
        bus(0, 'h0, c);
        bus(1, 'h10, 'h1);
        cyc(0);
        cmp("irq", 0, irq);
        bus(0, 'h10, 'h4);
        bus(1, 'h14, 'h4);
        trip <= 1'b0;
        cyc(0);
        cmp("irq", 1, irq);
        cmp("failsafe", 1, failsafe);
        bus(1, 'h0, 'h1);
        cyc(0);
        cmp("failsafe", 0, failsafe);
        bus(0, 'hc, 'h2);
        bus(0, 'h0, 'h1);
        bus(1, 'h0, 'h3f00);
        commError <= 1'b1;
        @(posedge mclk);
        commError <= 1'b0;
        cyc(1);
        cmp("failsafe", 1, failsafe);
        bus(0, 'h0, 'h3f00);
        bus(0, 'h20, 'h0);
        stop_test;
    end
endmodule
